/* logic/chgirq_map.svh */
// Register offsets, field positions and reset values of the charger register bank.
`ifndef CHGIRQ_MAP_SVH
`define CHGIRQ_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define CHGIRQ_OFF_RSVD_CFG   8'h70
`define CHGIRQ_OFF_CONTROL    8'h71
`define CHGIRQ_OFF_EVT_STATUS 8'h78
`define CHGIRQ_OFF_EVT_ENABLE 8'h79
`define CHGIRQ_OFF_STATE_RB   8'h7a

// ****************************************************************
// Field positions
// ****************************************************************
`define CHGIRQ_CTL_SUSPEND    7
`define CHGIRQ_CTL_RSVD       6
`define CHGIRQ_CTL_TOT_HI     5
`define CHGIRQ_CTL_TOT_LO     4
`define CHGIRQ_CTL_PRE_HI     3
`define CHGIRQ_CTL_PRE_LO     2
`define CHGIRQ_CTL_OVP_HI     1
`define CHGIRQ_CTL_OVP_LO     0
`define CHGIRQ_ST_TIMER_IRQ   7
`define CHGIRQ_ST_TEMP_IRQ    6
`define CHGIRQ_ST_INPUT_IRQ   5
`define CHGIRQ_ST_CHG_IRQ     4
`define CHGIRQ_EN_TOTAL       7
`define CHGIRQ_EN_TEMP_IN     6
`define CHGIRQ_EN_IN_CON      5
`define CHGIRQ_EN_EOC_IN      4
`define CHGIRQ_EN_PRE         3
`define CHGIRQ_EN_TEMP_OUT    2
`define CHGIRQ_EN_IN_DIS      1
`define CHGIRQ_EN_EOC_OUT     0

// ****************************************************************
// Reset values
// ****************************************************************
`define CHGIRQ_RST_RSVD_CFG   8'h00
`define CHGIRQ_RST_CONTROL    8'h00
`define CHGIRQ_RST_IRQ_STAT   4'h0
`define CHGIRQ_RST_ENABLE     8'h00
`define CHGIRQ_RD_UNMAPPED    8'h00

`endif

/* logic/chgirq_pkg.sv */
// Types shared by the charger register bank.
package chgirq_pkg;

  // Live status from the charger analog and state machine.
  typedef struct packed {
    logic       total_timeout;
    logic       precondition_timeout;
    logic       temperature_valid;
    logic       supply_valid;
    logic       end_of_charge;
    logic [1:0] charging_state;
    logic       ac_detect;
  } chgirq_status_t;

  // Settings handed to the charger.
  typedef struct packed {
    logic       charge_suspend;
    logic [1:0] total_timeout_select;
    logic [1:0] precondition_timeout_select;
    logic [1:0] input_overvoltage_threshold_select;
  } chgirq_ctrl_t;

endpackage

/* logic/chgirq_regs.sv */
// Charger control, status and event interrupt register bank.
`include "chgirq_map.svh"

module chgirq_regs
(
  input  wire logic                   clk_sys_in,
  input  wire logic                   nrst_in,
  input  wire logic [7:0]             addr_in,
  input  wire logic [7:0]             wdata_in,
  input  wire logic                   wr_in,
  input  wire logic                   rd_in,
  output logic      [7:0]             rdata_out,
  input  wire chgirq_pkg::chgirq_status_t status_in,
  output chgirq_pkg::chgirq_ctrl_t    ctrl_out,
  output logic                        irq_out
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  chgirq_pkg::chgirq_status_t sync1_q;
  chgirq_pkg::chgirq_status_t sync2_q;
  chgirq_pkg::chgirq_status_t prev_q;
  logic       [7:0]           rsvd_cfg_q;
  logic       [7:0]           control_q;
  logic       [3:0]           arm_q;
  logic       [7:0]           enable_q;
  logic       [7:0]           rdata_q;
  logic                       irq_q;
  logic       [7:0]           status_rd;
  logic       [7:0]           state_rd;
  logic                       supply_ok;
  logic                       ev_total;
  logic                       ev_pre;
  logic                       ev_temp_in;
  logic                       ev_temp_out;
  logic                       ev_in_con;
  logic                       ev_in_dis;
  logic                       ev_eoc_in;
  logic                       ev_eoc_out;
  logic                       irq_d;

  // Status pins come from analog and another timing domain, so two flops each.
  always_ff @(posedge clk_sys_in)
  begin
    if (!nrst_in)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q  <= '0;
    end
    else
    begin
      sync1_q <= status_in;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // ****************************************************************
  // Writable registers
  // ****************************************************************

  // Reserved configuration byte holds whatever software writes.
  always_ff @(posedge clk_sys_in)
  begin
    if (!nrst_in)
      rsvd_cfg_q <= `CHGIRQ_RST_RSVD_CFG;
    else if (wr_in && addr_in == `CHGIRQ_OFF_RSVD_CFG)
      rsvd_cfg_q <= wdata_in;
  end

  // Control register: suspend, timer selects and overvoltage select.
  always_ff @(posedge clk_sys_in)
  begin
    if (!nrst_in)
      control_q <= `CHGIRQ_RST_CONTROL;
    else if (wr_in && addr_in == `CHGIRQ_OFF_CONTROL)
      control_q <= wdata_in;
  end

  // Group arm bits live in the upper half of the event status register.
  always_ff @(posedge clk_sys_in)
  begin
    if (!nrst_in)
      arm_q <= `CHGIRQ_RST_IRQ_STAT;
    else if (wr_in && addr_in == `CHGIRQ_OFF_EVT_STATUS)
      arm_q <= wdata_in[7:4];
  end

  // Per-event interrupt enables.
  always_ff @(posedge clk_sys_in)
  begin
    if (!nrst_in)
      enable_q <= `CHGIRQ_RST_ENABLE;
    else if (wr_in && addr_in == `CHGIRQ_OFF_EVT_ENABLE)
      enable_q <= wdata_in;
  end

  // Settings driven to the charger straight from the control register.
  assign ctrl_out.charge_suspend                     = control_q[`CHGIRQ_CTL_SUSPEND];
  assign ctrl_out.total_timeout_select               = control_q[5:4];
  assign ctrl_out.precondition_timeout_select        = control_q[3:2];
  assign ctrl_out.input_overvoltage_threshold_select = control_q[1:0];

  // ****************************************************************
  // Event detection
  // ****************************************************************

  // Timer, temperature and end-of-charge edges only count with a valid supply.
  assign supply_ok   = sync2_q.supply_valid & prev_q.supply_valid;
  assign ev_total    = supply_ok & sync2_q.total_timeout & ~prev_q.total_timeout;
  assign ev_pre      = supply_ok & sync2_q.precondition_timeout
                       & ~prev_q.precondition_timeout;
  assign ev_temp_in  = supply_ok & sync2_q.temperature_valid & ~prev_q.temperature_valid;
  assign ev_temp_out = supply_ok & ~sync2_q.temperature_valid & prev_q.temperature_valid;
  assign ev_in_con   = sync2_q.supply_valid & ~prev_q.supply_valid;
  assign ev_in_dis   = ~sync2_q.supply_valid & prev_q.supply_valid;
  assign ev_eoc_in   = supply_ok & sync2_q.end_of_charge & ~prev_q.end_of_charge;
  assign ev_eoc_out  = supply_ok & ~sync2_q.end_of_charge & prev_q.end_of_charge;

  // An interrupt needs the event, its enable and its group arm bit.
  always_comb
  begin
    irq_d = 1'b0;
    if (arm_q[3] && enable_q[`CHGIRQ_EN_TOTAL] && ev_total)
      irq_d = 1'b1;
    if (arm_q[3] && enable_q[`CHGIRQ_EN_PRE] && ev_pre)
      irq_d = 1'b1;
    if (arm_q[2] && enable_q[`CHGIRQ_EN_TEMP_IN] && ev_temp_in)
      irq_d = 1'b1;
    if (arm_q[2] && enable_q[`CHGIRQ_EN_TEMP_OUT] && ev_temp_out)
      irq_d = 1'b1;
    if (arm_q[1] && enable_q[`CHGIRQ_EN_IN_CON] && ev_in_con)
      irq_d = 1'b1;
    if (arm_q[1] && enable_q[`CHGIRQ_EN_IN_DIS] && ev_in_dis)
      irq_d = 1'b1;
    if (arm_q[0] && enable_q[`CHGIRQ_EN_EOC_IN] && ev_eoc_in)
      irq_d = 1'b1;
    if (arm_q[0] && enable_q[`CHGIRQ_EN_EOC_OUT] && ev_eoc_out)
      irq_d = 1'b1;
  end

  // Pending request holds until the status register is read; a new event wins.
  always_ff @(posedge clk_sys_in)
  begin
    if (!nrst_in)
      irq_q <= 1'b0;
    else if (irq_d)
      irq_q <= 1'b1;
    else if (rd_in && addr_in == `CHGIRQ_OFF_EVT_STATUS)
      irq_q <= 1'b0;
  end

  assign irq_out = irq_q;

  // ****************************************************************
  // Read path
  // ****************************************************************

  // Event status: arm bits above, live flags below.
  always_comb
  begin
    status_rd      = '0;
    status_rd[7:4] = arm_q;
    status_rd[3]   = sync2_q.precondition_timeout | sync2_q.total_timeout;
    status_rd[2]   = sync2_q.temperature_valid;
    status_rd[1]   = sync2_q.supply_valid;
    status_rd[0]   = sync2_q.end_of_charge;
  end

  // State readback with reserved bits at zero.
  always_comb
  begin
    state_rd      = '0;
    state_rd[5:4] = sync2_q.charging_state;
    state_rd[1]   = sync2_q.ac_detect;
  end

  // Read data is registered and stands in the cycle after the strobe only.
  always_ff @(posedge clk_sys_in)
  begin
    if (!nrst_in)
      rdata_q <= `CHGIRQ_RD_UNMAPPED;
    else if (rd_in)
    begin
      case (addr_in)
        `CHGIRQ_OFF_RSVD_CFG:   rdata_q <= rsvd_cfg_q;
        `CHGIRQ_OFF_CONTROL:    rdata_q <= control_q;
        `CHGIRQ_OFF_EVT_STATUS: rdata_q <= status_rd;
        `CHGIRQ_OFF_EVT_ENABLE: rdata_q <= enable_q;
        `CHGIRQ_OFF_STATE_RB:   rdata_q <= state_rd;
        default:                rdata_q <= `CHGIRQ_RD_UNMAPPED;
      endcase
    end
    else
      rdata_q <= `CHGIRQ_RD_UNMAPPED;
  end

  assign rdata_out = rdata_q;

endmodule

/* bench/chgirq_regs_sva.sv */
// Port assertions for the charger register bank.
module chgirq_regs_sva
(
  input wire logic                       clk_sys_in,
  input wire logic                       nrst_in,
  input wire logic [7:0]                 addr_in,
  input wire logic [7:0]                 wdata_in,
  input wire logic                       wr_in,
  input wire logic                       rd_in,
  input wire logic [7:0]                 rdata_out,
  input wire chgirq_pkg::chgirq_status_t status_in,
  input wire chgirq_pkg::chgirq_ctrl_t   ctrl_out,
  input wire logic                       irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Checks
  // ****
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  logic                       nr_q;
  logic                       ok_q;
  chgirq_pkg::chgirq_status_t st_q;
  // Status has been steady long enough to pass both sync stages.
  always_ff @(posedge clk_sys_in)
  begin
    nr_q <= nrst_in;
    st_q <= status_in;
    ok_q <= nrst_in && nr_q && status_in == st_q;
  end
  wire w71 = wr_in && addr_in == 8'h71;
  wire r78 = rd_in && addr_in == 8'h78;
  wire sty = ok_q && status_in == st_q;
  AST_RD_IDLE: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data not zero outside a read");
  // A control write shows on the charger settings one cycle later.
  AST_CTRL_WR: assert property (w71 |=>
    ctrl_out == {$past(wdata_in[7]), $past(wdata_in[5:0])})
    else $error("control outputs do not follow the write");
  AST_CTRL_HOLD: assert property (!w71 |=> $stable(ctrl_out))
    else $error("control outputs moved without a write");
  // Reads return what was written, or the settled live status.
  AST_RDBACK: assert property (w71 ##1 (rd_in && addr_in == 8'h71) |=>
    rdata_out == $past(wdata_in, 2))
    else $error("control read back differs");
  AST_STATE_RB: assert property (rd_in && addr_in == 8'h7a && sty |=>
    rdata_out == {2'b00, $past(status_in.charging_state), 2'b00,
                  $past(status_in.ac_detect), 1'b0})
    else $error("state read back differs");
  AST_FLAGS: assert property (r78 && sty && status_in.supply_valid |=>
    rdata_out[3:0] == {$past(status_in.total_timeout | status_in.precondition_timeout),
                       $past(status_in.temperature_valid),
                       $past(status_in.supply_valid),
                       $past(status_in.end_of_charge)})
    else $error("status flags differ");
  AST_IRQ_CAUSE: assert property ($rose(irq_out) |-> $past(status_in, 3) != $past(status_in, 4))
    else $error("interrupt rose without a status change");
  AST_IRQ_HOLD: assert property (irq_out && !r78 |=> irq_out)
    else $error("interrupt dropped without a status read");
  AST_IRQ_CLEAR: assert property ($fell(irq_out) |-> $past(rd_in) && $past(addr_in) == 8'h78)
    else $error("interrupt fell without a status read");
  COV_WR: cover property (w71);
  COV_IRQ_SET: cover property ($rose(irq_out));
  COV_IRQ_CLR: cover property ($fell(irq_out));
endmodule

bind chgirq_regs chgirq_regs_sva i_chgirq_regs_sva (.clk_sys_in, .nrst_in, .addr_in, .wdata_in,
  .wr_in, .rd_in, .rdata_out, .status_in, .ctrl_out, .irq_out);

/* bench/chgirq_charger_model.sv */
// Behavioural model of the charger status lines.
module chgirq_charger_model
(
  input  wire logic                  clk_sys_in,
  input  wire logic [7:0]            set_in,
  output chgirq_pkg::chgirq_status_t status_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Status levels move on a clock edge, as the charger logic updates them.
  initial status_out = '0;
  always @(posedge clk_sys_in)
  begin
    status_out <= chgirq_pkg::chgirq_status_t'(set_in);
  end
endmodule

/* bench/chgirq_regs_tb.sv */
// Self-checking testbench for the charger register bank.
module chgirq_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                       clk_sys_in = 1'b0;
  logic                       nrst_in = 1'b0;
  logic [7:0]                 addr_in = 8'h00;
  logic [7:0]                 wdata_in = 8'h00;
  logic                       wr_in = 1'b0;
  logic                       rd_in = 1'b0;
  logic [7:0]                 set_q = 8'h00;
  logic [7:0]                 rdata_out;
  chgirq_pkg::chgirq_status_t status_in;
  chgirq_pkg::chgirq_ctrl_t   ctrl_out;
  logic                       irq_out;
  int                         n_errors = 0;
  int                         n_compared = 0;
  logic [7:0]                 ev_b [8] = '{8'h18, 8'h10, 8'h30, 8'h10, 8'h10, 8'h00, 8'h10, 8'h10};
  logic [7:0]                 ev_a [8] = '{8'h10, 8'h00, 8'h10, 8'h50, 8'h18, 8'h10, 8'h30, 8'h90};
  logic [7:0]                 regs [6] = '{8'h70, 8'h71, 8'h78, 8'h79, 8'h7a, 8'h72};
  // ****
  // Harness
  // ****
  always #12.5 clk_sys_in = ~clk_sys_in;
  chgirq_regs i_chgirq_regs (.clk_sys_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .status_in, .ctrl_out, .irq_out);
  chgirq_charger_model i_chgirq_charger_model (.clk_sys_in, .set_in(set_q), .status_out(status_in));
  // Comparison, bus cycles and status steps.
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1;
    chk("rdata", exp, rdata_out);
  endtask
  task automatic ev(input logic [7:0] v);
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
    set_q <= v;
    repeat (4) @(posedge clk_sys_in);
    #1;
  endtask
  function automatic logic [7:0] fl(input logic [7:0] s);
    return {4'h0, s[7] | s[6], s[5], s[4], s[3]};
  endfunction
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog cuts a hung run short.
  initial
  begin
    #(25 * 20000);
    n_errors++;
    end_of_test();
  end
  // Main test sequence.
  initial
  begin
    repeat (8) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    foreach (regs[k]) rd(regs[k], 8'h00);
    chk("irq", 8'h00, {7'h00, irq_out});
    $display("reset test done");
    wr(8'h71, 8'ha5);
    rd(8'h71, 8'ha5);
    chk("ctrl", 8'h65, {1'b0, ctrl_out});
    wr(8'h71, 8'h5a);
    wr(8'h72, 8'hff);
    wr(8'h7a, 8'hff);
    rd(8'h72, 8'h00);
    rd(8'h71, 8'h5a);
    chk("ctrl", 8'h1a, {1'b0, ctrl_out});
    $display("control test done");
    wr(8'h78, 8'hff);
    ev(8'hfd);
    rd(8'h7a, 8'h22);
    rd(8'h78, 8'hff);
    ev(8'h02);
    rd(8'h7a, 8'h10);
    rd(8'h78, 8'hf0);
    $display("status test done");
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h79, 8'h00);
      wr(8'h78, 8'h10 << (i % 4));
      ev(ev_b[i]);
      ev(ev_a[i]);
      chk("masked irq", 8'h00, {7'h00, irq_out});
      ev(ev_b[i]);
      wr(8'h79, 8'h01 << i);
      ev(ev_a[i]);
      chk("irq", 8'h01, {7'h00, irq_out});
      rd(8'h78, (8'h10 << (i % 4)) | fl(ev_a[i]));
      chk("cleared irq", 8'h00, {7'h00, irq_out});
    end
    $display("event test done");
    wr(8'h78, 8'h10);
    wr(8'h79, 8'h10);
    ev(8'h00);
    ev(8'h08);
    chk("gated irq", 8'h00, {7'h00, irq_out});
    $display("gating test done");
    end_of_test();
  end
endmodule
